// >>> design/tbc_regs.svh
// register map, field positions and reset values of the timer base counter
// Contract
// - a count value of zero means the counter sits at BOTTOM
// - a count value of all ones means the counter sits at MAX
// - TOP is the period value or channel A compare value, by waveform mode
// - UPDATE fires at BOTTOM or at TOP, chosen by waveform mode
// - count, period, period buffer, channel values and buffers are 16 bits
// - count is compared with every channel value; matches give flags and events
// - clock source select picks a prescaler output or an event channel
// - after reset no clock is selected and the counter stays stopped
// - period and compare buffers set valid on write, clear at UPDATE copy
// - channel register and its buffer are both directly readable and writable
// - counting follows the direction bit; up at TOP loads zero next
// - counting down at BOTTOM reloads TOP; direction may change anytime
// - a software count write wins over count, clear and reload
// - event actions can steer up/down counting or quadrature decode counting
// - unbuffered period writes act at once; buffered ones only at UPDATE
// - event source select feeds channel A, following event channels feed B, C, D
// - a capture on an enabled channel copies the count value into it
// - with period below 0x8000 a pin capture stores edge polarity in the MSB
// - input capture action captures each event unless register and buffer are both full, and sets the channel flag
`ifndef TBC_REGS_SVH
`define TBC_REGS_SVH

// ***************************************************************
// byte offsets on the apb bus
// ***************************************************************
`define TBC_OFF_CLK    8'h00
`define TBC_OFF_WAVE   8'h04
`define TBC_OFF_EVENT  8'h08
`define TBC_OFF_FLAGS  8'h0c
`define TBC_OFF_STATUS 8'h10
`define TBC_OFF_COUNT  8'h14
`define TBC_OFF_PER    8'h18
`define TBC_OFF_PERIOD_BUFFER 8'h1c
`define TBC_GRP_CC     4'h2
`define TBC_GRP_CCBUF  4'h3

// ***************************************************************
// field positions
// ***************************************************************
`define TBC_CCEN_LSB   4
`define TBC_EVENT_ACTION_SELECT_LSB  5
`define TBC_DIR_BIT    0
`define TBC_BUFEN_BIT  1
`define TBC_ST_PERBV   8
`define TBC_ST_CCBV    9
`define TBC_ST_RUN     16
`define TBC_ST_DOWN    17
`define TBC_ST_MAX     18

// ***************************************************************
// reset values and limits
// ***************************************************************
`define TBC_RST_COUNT  16'h0000
`define TBC_RST_PER    16'hffff
`define TBC_MSB_LIMIT  16'h8000
`define TBC_CLK_EVT0   4'h8

`endif

// >>> design/tbc_pkg.sv
// types shared by the timer base counter design
package tbc_pkg;
    // event action field
    typedef enum logic [1:0] {
        TBC_EA_OFF,
        TBC_EA_CAPT,
        TBC_EA_UPDN,
        TBC_EA_QUADRATURE_DECODER
    } tbc_event_action_select_t;
    // waveform generator mode field
    typedef enum logic [1:0] {
        TBC_WG_NORMAL,
        TBC_WG_FRQ,
        TBC_WG_SS,
        TBC_WG_DS
    } tbc_wg_t;
endpackage : tbc_pkg

// >>> design/tbc_chan.sv
// one compare or capture channel with its buffer
`timescale 1ns/10ps
module tbc_chan (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // timebase
    input  wire logic [15:0] i_cnt,
    input  wire logic        i_tick,
    input  wire logic        i_update,
    // capture
    input  wire logic        i_capt_mode,
    input  wire logic        i_capt,
    input  wire logic [15:0] i_capt_val,
    // software access
    input  wire logic        i_wr_cc,
    input  wire logic        i_wr_buf,
    input  wire logic        i_rd_cc,
    input  wire logic        i_clr_flag,
    input  wire logic [15:0] i_wdata,
    // state
    output logic      [15:0] o_cc,
    output logic      [15:0] o_buf,
    output logic             o_bv,
    output logic             o_flag,
    output logic             o_match
);
    logic cap_direct;
    logic cap_buf;
    logic xfer;

    // queue moves: empty register takes the capture, else the buffer does
    assign xfer       = i_capt_mode & o_bv & (~o_flag | i_rd_cc);
    assign cap_direct = i_capt_mode & i_capt & ~o_flag & ~o_bv;
    assign cap_buf    = i_capt_mode & i_capt & ~cap_direct & (~o_bv | xfer);

    // channel register: software write beats every hardware load
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cc <= 16'h0000;
        end else if (i_wr_cc) begin
            o_cc <= i_wdata;
        end else if (cap_direct) begin
            o_cc <= i_capt_val;
        end else if (xfer || (!i_capt_mode && i_update && o_bv)) begin
            o_cc <= o_buf;
        end
    end

    // buffer register
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_buf <= 16'h0000;
        end else if (i_wr_buf) begin
            o_buf <= i_wdata;
        end else if (cap_buf) begin
            o_buf <= i_capt_val;
        end
    end

    // buffer valid: a set in the same cycle as the clear wins
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bv <= 1'b0;
        end else if (!i_capt_mode) begin
            o_bv <= i_wr_buf | (o_bv & ~i_update);
        end else begin
            o_bv <= cap_buf | (o_bv & ~xfer);
        end
    end

    // match pulse, one clock late, gated by the count strobe so a stopped counter never fires
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_match <= 1'b0;
        end else begin
            o_match <= ~i_capt_mode & i_tick & (i_cnt == o_cc);
        end
    end

    // channel flag: reading a capture consumes it; the next entry refills it
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_flag <= 1'b0;
        end else if (i_capt_mode) begin
            o_flag <= cap_direct | xfer | (o_flag & ~i_clr_flag & ~i_rd_cc);
        end else begin
            o_flag <= o_match | (o_flag & ~i_clr_flag);
        end
    end
endmodule : tbc_chan

// >>> design/tbc_timer.sv
// top of the timer base counter: apb registers, counter, channels
`timescale 1ns/10ps
`include "tbc_regs.svh"
module tbc_timer #(
    parameter int N_CH   = 4,
    parameter int N_EVCH = 8
) (
    // clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    // apb slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // prescaler taps and event network
    input  wire logic [6:0]        i_presc_tick,
    input  wire logic [N_EVCH-1:0] i_evt,
    input  wire logic [N_EVCH-1:0] i_evt_pin,
    input  wire logic [N_EVCH-1:0] i_evt_rise,
    input  wire logic              i_quadrature_decoder_dir,
    // events and state out
    output tbc_pkg::tbc_wg_t       o_wave_mode,
    output logic      [N_CH-1:0]   o_cc_event,
    output logic      [N_CH-1:0]   o_cc_flag,
    output logic                   o_update_event,
    output logic      [15:0]       o_count
);
    import tbc_pkg::*;

    localparam int EVW = $clog2(N_EVCH);

    // ***************************************************************
    // elaboration checks
    // ***************************************************************
    // the address map holds four channel slots and a 3-bit event select
    if (N_CH < 1 || N_CH > 4 || N_EVCH != 8) begin : g_bad_param
        $error("tbc_timer: N_CH must be 1..4 and N_EVCH must be 8");
    end

    // ***************************************************************
    // functions
    // ***************************************************************
    // event channel serving channel k, wrapping around the network
    function automatic logic [EVW-1:0] ev_idx(input logic [EVW-1:0] sel,
                                              input int k);
        return sel + EVW'(k);
    endfunction : ev_idx

    // count strobe picked by the clock source select; zero is off
    function automatic logic src_tick(input logic [3:0] sel,
                                      input logic [6:0] presc,
                                      input logic [N_EVCH-1:0] evt);
        logic t;
        t = 1'b0;
        if (sel >= `TBC_CLK_EVT0) begin
            t = evt[EVW'(sel - `TBC_CLK_EVT0)];
        end else if (sel != 4'h0) begin
            t = presc[3'(sel - 4'h1)];
        end
        return t;
    endfunction : src_tick

    // ***************************************************************
    // registers and wires
    // ***************************************************************
    logic [3:0]      clk_sel_ff;
    tbc_wg_t         wave_ff;
    logic [3:0]      ccen_ff;
    logic [EVW-1:0]  event_source_select_ff;
    tbc_event_action_select_t      event_action_select_ff;
    logic            dir_ff;
    logic            bufen_ff;
    logic [15:0]     cnt_ff;
    logic [15:0]     per_ff;
    logic [15:0]     period_buffer_ff;
    logic            perbv_ff;
    logic            upd_ev_ff;
    logic            wr_en;
    logic            rd_en;
    logic            grp_cc;
    logic            grp_buf;
    logic [1:0]      ch_sel;
    logic            mapped;
    logic            wr_cnt;
    logic            wr_per;
    logic            tick;
    logic            down;
    logic            evt_ctrl;
    logic            at_bottom;
    logic            at_max;
    logic            at_top;
    logic            upd_at_top;
    logic            update;
    logic [15:0]     top;
    logic [15:0]     cc_w    [N_CH];
    logic [15:0]     buf_w   [N_CH];
    logic [N_CH-1:0] bv_w;
    logic [3:0]      bv_pad;
    logic [3:0]      flag_pad;

    // ***************************************************************
    // apb decode
    // ***************************************************************
    // zero wait states: every access phase ends on its first edge
    assign o_pready = 1'b1;
    assign wr_en    = i_psel & i_penable & i_pwrite;
    assign rd_en    = i_psel & i_penable & ~i_pwrite;
    assign grp_cc   = (i_paddr[7:4] == `TBC_GRP_CC) && (i_paddr[1:0] == 2'b00) &&
                      (32'(i_paddr[3:2]) < N_CH);
    assign grp_buf  = (i_paddr[7:4] == `TBC_GRP_CCBUF) && (i_paddr[1:0] == 2'b00) &&
                      (32'(i_paddr[3:2]) < N_CH);
    assign ch_sel   = i_paddr[3:2];
    assign mapped   = (i_paddr <= `TBC_OFF_PERIOD_BUFFER) | grp_cc | grp_buf;
    assign o_pslverr = i_psel & i_penable & (~mapped | (i_paddr[1:0] != 2'b00));
    assign wr_cnt   = wr_en & (i_paddr == `TBC_OFF_COUNT);
    assign wr_per   = wr_en & (i_paddr == `TBC_OFF_PER);

    // control registers
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clk_sel_ff <= 4'h0;
            wave_ff    <= TBC_WG_NORMAL;
            ccen_ff    <= 4'h0;
            event_source_select_ff   <= '0;
            event_action_select_ff   <= TBC_EA_OFF;
            dir_ff     <= 1'b0;
            bufen_ff   <= 1'b0;
        end else if (wr_en) begin
            case (i_paddr)
                `TBC_OFF_CLK: begin
                    clk_sel_ff <= i_pwdata[3:0];
                end
                `TBC_OFF_WAVE: begin
                    wave_ff <= tbc_wg_t'(i_pwdata[1:0]);
                    ccen_ff <= i_pwdata[`TBC_CCEN_LSB +: 4];
                end
                `TBC_OFF_EVENT: begin
                    event_source_select_ff <= i_pwdata[EVW-1:0];
                    event_action_select_ff <= tbc_event_action_select_t'(i_pwdata[`TBC_EVENT_ACTION_SELECT_LSB +: 2]);
                end
                `TBC_OFF_FLAGS: begin
                    dir_ff   <= i_pwdata[`TBC_DIR_BIT];
                    bufen_ff <= i_pwdata[`TBC_BUFEN_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // ***************************************************************
    // count control
    // ***************************************************************
    // the up/down and quadrature event actions take the count strobe and direction from the network;
    // they only run once software has picked an event channel as clock
    assign evt_ctrl = (event_action_select_ff == TBC_EA_UPDN) || (event_action_select_ff == TBC_EA_QUADRATURE_DECODER);
    always_comb begin
        tick = src_tick(clk_sel_ff, i_presc_tick, i_evt);
        down = dir_ff;
        if (evt_ctrl) begin
            tick = (clk_sel_ff >= `TBC_CLK_EVT0) & i_evt[event_source_select_ff];
            if (event_action_select_ff == TBC_EA_UPDN) begin
                down = i_evt[ev_idx(event_source_select_ff, 1)];
            end else begin
                down = i_quadrature_decoder_dir;
            end
        end
    end

    assign at_bottom  = (cnt_ff == 16'h0000);
    assign at_max     = (cnt_ff == 16'hffff);
    assign top        = (wave_ff == TBC_WG_FRQ) ? cc_w[0] : per_ff;
    assign at_top     = (cnt_ff == top);
    assign upd_at_top = (wave_ff == TBC_WG_NORMAL) || (wave_ff == TBC_WG_FRQ);
    assign update     = tick & (upd_at_top ? at_top : at_bottom);

    // counter: software write first, then clear at top or reload at bottom
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= `TBC_RST_COUNT;
        end else if (wr_cnt) begin
            cnt_ff <= i_pwdata[15:0];
        end else if (tick) begin
            if (!down) begin
                cnt_ff <= at_top ? 16'h0000 : cnt_ff + 16'h0001;
            end else begin
                cnt_ff <= at_bottom ? top : cnt_ff - 16'h0001;
            end
        end
    end

    // ***************************************************************
    // period and its buffer
    // ***************************************************************
    // buffering keeps a running period from changing mid-sequence
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            per_ff <= `TBC_RST_PER;
        end else if (wr_per && !bufen_ff) begin
            per_ff <= i_pwdata[15:0];
        end else if (update && perbv_ff) begin
            per_ff <= period_buffer_ff;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            period_buffer_ff <= `TBC_RST_PER;
            perbv_ff  <= 1'b0;
        end else begin
            if ((wr_per && bufen_ff) || (wr_en && i_paddr == `TBC_OFF_PERIOD_BUFFER)) begin
                period_buffer_ff <= i_pwdata[15:0];
                perbv_ff  <= 1'b1;
            end else if (update) begin
                perbv_ff  <= 1'b0;
            end
        end
    end

    // update event out, registered
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            upd_ev_ff <= 1'b0;
        end else begin
            upd_ev_ff <= update;
        end
    end

    // ***************************************************************
    // channels
    // ***************************************************************
    for (genvar k = 0; k < N_CH; k++) begin : g_ch
        logic [EVW-1:0] idx;
        logic           capt;
        logic [15:0]    cval;
        assign idx  = ev_idx(event_source_select_ff, k);
        assign capt = (event_action_select_ff == TBC_EA_CAPT) & ccen_ff[k] & i_evt[idx];
        // short periods leave the msb free to hold the pin edge
        assign cval = ((per_ff < `TBC_MSB_LIMIT) && i_evt_pin[idx]) ?
                      {i_evt_rise[idx], cnt_ff[14:0]} : cnt_ff;
        tbc_chan u_chan (
            .i_clock    (i_clock),
            .i_rst_n    (i_rst_n),
            .i_cnt      (cnt_ff),
            .i_tick     (tick),
            .i_update   (update),
            .i_capt_mode(event_action_select_ff == TBC_EA_CAPT),
            .i_capt     (capt),
            .i_capt_val (cval),
            .i_wr_cc    (wr_en & grp_cc & (32'(ch_sel) == k)),
            .i_wr_buf   (wr_en & grp_buf & (32'(ch_sel) == k)),
            .i_rd_cc    (rd_en & grp_cc & (32'(ch_sel) == k)),
            .i_clr_flag (wr_en & (i_paddr == `TBC_OFF_STATUS) & i_pwdata[k]),
            .i_wdata    (i_pwdata[15:0]),
            .o_cc       (cc_w[k]),
            .o_buf      (buf_w[k]),
            .o_bv       (bv_w[k]),
            .o_flag     (o_cc_flag[k]),
            .o_match    (o_cc_event[k])
        );
    end

    assign bv_pad   = 4'(bv_w);
    assign flag_pad = 4'(o_cc_flag);

    // ***************************************************************
    // read mux and outputs
    // ***************************************************************
    always_comb begin
        o_prdata = 32'h0000_0000;
        if (rd_en) begin
            if (grp_cc) begin
                o_prdata = {16'h0000, cc_w[ch_sel]};
            end else if (grp_buf) begin
                o_prdata = {16'h0000, buf_w[ch_sel]};
            end else begin
                case (i_paddr)
                    `TBC_OFF_CLK:    o_prdata = {28'h0, clk_sel_ff};
                    `TBC_OFF_WAVE:   o_prdata = {24'h0, ccen_ff, 2'b00, wave_ff};
                    `TBC_OFF_EVENT:  o_prdata = {25'h0, event_action_select_ff, 2'b00, event_source_select_ff};
                    `TBC_OFF_FLAGS:  o_prdata = {30'h0, bufen_ff, dir_ff};
                    `TBC_OFF_STATUS: o_prdata = {13'h0, at_max, down, clk_sel_ff != 4'h0,
                                                 3'h0, bv_pad, perbv_ff, 4'h0, flag_pad};
                    `TBC_OFF_COUNT:  o_prdata = {16'h0000, cnt_ff};
                    `TBC_OFF_PER:    o_prdata = {16'h0000, per_ff};
                    `TBC_OFF_PERIOD_BUFFER: o_prdata = {16'h0000, period_buffer_ff};
                    default:         o_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    assign o_update_event = upd_ev_ff;
    assign o_count        = cnt_ff;
    assign o_wave_mode    = wave_ff;

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_wrap_up;
        tick && !down && at_top && !wr_cnt;
    endsequence
    sequence s_wrap_dn;
        tick && down && at_bottom && !wr_cnt;
    endsequence

    property p_top_clear;
        s_wrap_up |=> (cnt_ff == 16'h0000);
    endproperty
    a_top_clear: assert property (p_top_clear) else $error("up count at top did not clear");

    property p_bottom_reload;
        logic [15:0] t;
        (s_wrap_dn, t = top) |=> (cnt_ff == t);
    endproperty
    a_bottom_reload: assert property (p_bottom_reload) else $error("down count missed reload");

    property p_sw_write;
        wr_cnt |=> (cnt_ff == $past(i_pwdata[15:0]));
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("count write not applied");

    property p_off_stopped;
        (clk_sel_ff == 4'h0) && !wr_cnt |=> $stable(cnt_ff);
    endproperty
    a_off_stopped: assert property (p_off_stopped) else $error("counter moved with no clock");

    property p_update_point;
        update |-> (upd_at_top ? (cnt_ff == top) : (cnt_ff == 16'h0000)) ##1 o_update_event;
    endproperty
    a_update_point: assert property (p_update_point) else $error("update at wrong point");

    property p_per_copy;
        update && perbv_ff && !wr_en |=> !perbv_ff && (per_ff == $past(period_buffer_ff));
    endproperty
    a_per_copy: assert property (p_per_copy) else $error("period buffer not copied");

    property p_per_hold;
        !update && !(wr_per && !bufen_ff) |=> $stable(per_ff);
    endproperty
    a_per_hold: assert property (p_per_hold) else $error("period changed outside update");

    property p_per_direct;
        wr_per && !bufen_ff |=> (per_ff == $past(i_pwdata[15:0]));
    endproperty
    a_per_direct: assert property (p_per_direct) else $error("unbuffered period not immediate");

    property p_capture_a;
        g_ch[0].capt && !o_cc_flag[0] && !bv_w[0] && !wr_en |=>
            o_cc_flag[0] && (cc_w[0] == $past(g_ch[0].cval));
    endproperty
    a_capture_a: assert property (p_capture_a) else $error("capture not stored in channel a");

    property p_match_a;
        (event_action_select_ff != TBC_EA_CAPT) && tick && (cnt_ff == cc_w[0]) |=> o_cc_event[0] ##1 o_cc_flag[0];
    endproperty
    a_match_a: assert property (p_match_a) else $error("compare match lost");
endmodule : tbc_timer

// >>> verification/tbc_evnet_model.sv
// prescaler tap and event channel model facing the timer
`timescale 1ns/10ps
module tbc_evnet_model (
    // clock
    input  wire logic       i_clock,
    // strobes into the timer
    output logic      [6:0] o_presc_tick,
    output logic      [7:0] o_evt
);
    // quiet between strobes
    initial begin
        o_presc_tick = 7'h00;
        o_evt        = 8'h00;
    end
    // strobe launched after an edge and held one cycle, so the timer sees it once
    task automatic fire(input logic [6:0] t, input logic [7:0] e);
        @(posedge i_clock);
        o_presc_tick <= t;
        o_evt        <= e;
        @(posedge i_clock);
        o_presc_tick <= 7'h00;
        o_evt        <= 8'h00;
    endtask : fire
endmodule : tbc_evnet_model

// >>> verification/timer_base_counter_capture_tb_top.sv
// self-checking bench for the timer base counter
`timescale 1ns/10ps
`include "tbc_regs.svh"
module timer_base_counter_capture_tb_top;
    import tbc_pkg::*;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, upd, rerr, qdir;
    logic [7:0]  paddr, evt_pin, evt_rise;
    logic [31:0] pwdata, prdata, rdata;
    logic [6:0]  ptick;
    logic [7:0]  evt;
    logic [3:0]  cce, ccf;
    logic [15:0] cnt;
    tbc_wg_t     wave;
    int          errors, num_checks;
    int          n_upd = 0, n_cce = 0;
    tbc_evnet_model u_tbc_evnet_model (.i_clock(clock), .o_presc_tick(ptick), .o_evt(evt));
    tbc_timer u_tbc_timer (.i_clock(clock), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_presc_tick(ptick),
        .i_evt(evt), .i_evt_pin(evt_pin), .i_evt_rise(evt_rise), .i_quadrature_decoder_dir(qdir),
        .o_wave_mode(wave), .o_cc_event(cce), .o_cc_flag(ccf), .o_update_event(upd),
        .o_count(cnt));
    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // pulse counters, so one-cycle outputs are never missed between reads
    always @(posedge clock) begin
        if (upd === 1'b1) n_upd <= n_upd + 1;
        if (cce[0] === 1'b1) n_cce <= n_cce + 1;
    end
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask : chk
    // apb transfer; held until pready is seen high, bounded wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            errors++;
            conclude();
        end
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg_%h", a), exp, rdata);
    endtask : rd
    task automatic tk(input logic [6:0] t, input logic [7:0] e, input int n);
        repeat (n) u_tbc_evnet_model.fire(t, e);
    endtask : tk
    // reset values, stopped counter, max flag, bad addresses
    task automatic t_reset();
        rd(`TBC_OFF_STATUS, 32'h0);
        rd(`TBC_OFF_PER, 32'h0000_ffff);
        tk(7'h7f, 8'hff, 2);
        rd(`TBC_OFF_COUNT, 32'h0);
        apb(1'b1, `TBC_OFF_COUNT, 32'h0000_ffff);
        rd(`TBC_OFF_STATUS, 32'h0004_0000);
        apb(1'b0, 8'h40, 32'h0);
        chk("pslverr", 32'h1, {31'h0, rerr});
        apb(1'b0, 8'h02, 32'h0);
        chk("pslverr", 32'h1, {31'h0, rerr});
    endtask : t_reset
    // tap select, up count wrap, down reload, buffered period
    task automatic t_count();
        apb(1'b1, `TBC_OFF_CLK, 32'h3);
        apb(1'b1, `TBC_OFF_PER, 32'h3);
        apb(1'b1, `TBC_OFF_COUNT, 32'h0);
        rd(`TBC_OFF_STATUS, 32'h0001_0000);
        tk(7'h01, 8'h0, 1);
        rd(`TBC_OFF_COUNT, 32'h0);
        tk(7'h04, 8'h0, 4);
        rd(`TBC_OFF_COUNT, 32'h0);
        chk("update", 32'h1, n_upd);
        apb(1'b1, `TBC_OFF_FLAGS, 32'h1);
        tk(7'h04, 8'h0, 2);
        rd(`TBC_OFF_COUNT, 32'h2);
        apb(1'b1, `TBC_OFF_FLAGS, 32'h2);
        apb(1'b1, `TBC_OFF_PER, 32'h5);
        rd(`TBC_OFF_STATUS, 32'h0001_010f);
        rd(`TBC_OFF_PER, 32'h3);
        tk(7'h04, 8'h0, 2);
        rd(`TBC_OFF_PER, 32'h5);
        rd(`TBC_OFF_STATUS, 32'h0001_000f);
    endtask : t_count
    // compare match and direct buffer access
    task automatic t_cmp();
        apb(1'b1, 8'h20, 32'h2);
        apb(1'b1, `TBC_OFF_WAVE, 32'h10);
        tk(7'h04, 8'h0, 3);
        apb(1'b1, 8'h30, 32'h1234);
        chk("cc_event", 32'h3, n_cce);
        rd(8'h30, 32'h1234);
        rd(`TBC_OFF_STATUS, 32'h0001_020f);
        tk(7'h04, 8'h0, 3);
        rd(8'h20, 32'h1234);
        apb(1'b1, `TBC_OFF_WAVE, 32'h11);
        apb(1'b1, `TBC_OFF_COUNT, 32'h1234);
        chk("wave", 32'h1, {30'h0, wave});
        tk(7'h04, 8'h0, 1);
        rd(`TBC_OFF_COUNT, 32'h0);
    endtask : t_cmp
    // input capture on channels a and b, queueing and edge polarity
    task automatic t_capt();
        apb(1'b1, `TBC_OFF_FLAGS, 32'h0);
        apb(1'b1, `TBC_OFF_PER, 32'h7fff);
        apb(1'b1, `TBC_OFF_STATUS, 32'hf);
        apb(1'b1, `TBC_OFF_EVENT, 32'h22);
        apb(1'b1, `TBC_OFF_WAVE, 32'h30);
        apb(1'b1, `TBC_OFF_COUNT, 32'h100);
        tk(7'h0, 8'h04, 1);
        tk(7'h0, 8'h08, 1);
        apb(1'b1, `TBC_OFF_COUNT, 32'h200);
        tk(7'h0, 8'h04, 1);
        rd(`TBC_OFF_STATUS, 32'h0001_0203);
        chk("cc_flag", 32'h3, {28'h0, ccf});
        rd(8'h20, 32'h100);
        rd(8'h20, 32'h200);
        rd(8'h24, 32'h100);
        evt_pin  <= 8'h04;
        evt_rise <= 8'h04;
        apb(1'b1, `TBC_OFF_COUNT, 32'h300);
        tk(7'h0, 8'h04, 1);
        rd(8'h20, 32'h8300);
        evt_rise <= 8'h00;
        apb(1'b1, `TBC_OFF_COUNT, 32'h8400);
        tk(7'h0, 8'h04, 1);
        rd(8'h20, 32'h0400);
    endtask : t_capt
    // event steered up/down and quadrature counting
    task automatic t_event_action_select();
        apb(1'b1, `TBC_OFF_CLK, {28'h0, `TBC_CLK_EVT0});
        apb(1'b1, `TBC_OFF_EVENT, 32'h40);
        apb(1'b1, `TBC_OFF_COUNT, 32'h10);
        tk(7'h0, 8'h01, 1);
        rd(`TBC_OFF_COUNT, 32'h11);
        tk(7'h0, 8'h03, 1);
        rd(`TBC_OFF_COUNT, 32'h10);
        apb(1'b1, `TBC_OFF_EVENT, 32'h60);
        qdir <= 1'b1;
        tk(7'h0, 8'h01, 1);
        rd(`TBC_OFF_COUNT, 32'h0f);
        apb(1'b1, `TBC_OFF_WAVE, 32'h3);
        apb(1'b1, `TBC_OFF_COUNT, 32'h0);
        tk(7'h0, 8'h01, 1);
        rd(`TBC_OFF_COUNT, 32'h7fff);
        chk("update", 32'h6, n_upd);
        chk("count", 32'h7fff, {16'h0, cnt});
    endtask : t_event_action_select
    initial begin
        {psel, penable, pwrite, qdir, rst_n} = 5'h0;
        {paddr, evt_pin, evt_rise, pwdata} = 56'h0;
        {errors, num_checks} = 64'h0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_count();
        t_cmp();
        t_capt();
        t_event_action_select();
        conclude();
    end
endmodule : timer_base_counter_capture_tb_top
